// ==== logic/bcs_pkg.sv ====
// Purpose: Shared constants for the branch and condition sequencer
// Assumes: 24-bit program addresses, 32-bit status words
// Notes: Status bit positions below match the datapath's status word
package bcs_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int COND_W = 5;
  localparam int REG_AW = 4;

  // Condition codes that need special handling
  localparam logic [4:0] COND_LCE = 5'h0F;
  localparam logic [4:0] COND_ALWAYS = 5'h1F;
  localparam logic [4:0] COND_CPL_BASE = 5'h10;
  localparam logic [4:0] COND_LT = 5'h01;
  localparam logic [4:0] COND_LE = 5'h02;
  localparam logic [4:0] COND_FLAG0 = 5'h09;
  localparam logic [4:0] COND_BM = 5'h0E;

  // Bit positions inside the arithmetic status word
  localparam int ST_AZ = 0;
  localparam int ST_AV = 1;
  localparam int ST_AN = 2;
  localparam int ST_AC = 3;
  localparam int ST_MN = 6;
  localparam int ST_MV = 7;
  localparam int ST_AF = 10;
  localparam int ST_SV = 11;
  localparam int ST_SZ = 12;
  localparam int ST_BTF = 18;

  // Bit positions inside mode control one
  localparam int MD_ALU_SATURATE_ENABLE = 13;
  localparam int MD_BM_LO = 17;
  localparam int MD_BM_HI = 18;

  // Loop count value that means expired
  localparam logic [31:0] LOOP_LAST = 32'h0000_0001;

  // Delay slots per branch, delayed call return offset, sequential step
  localparam logic [1:0] SLOT_COUNT = 2'h2;
  localparam logic [23:0] CALL_DB_OFS = 24'h00_0003;
  localparam logic [23:0] SEQ_STEP = 24'h00_0001;

  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam logic [3:0] REG_TARGET = 4'hC;
  localparam logic CTRL_RESET = 1'b1;

  // Branch kinds and target forms
  typedef enum logic [1:0] {
    BCS_JUMP, BCS_CALL, BCS_RTS, BCS_RTI
  } bcs_kind_t;
  typedef enum logic [1:0] {
    BCS_DIRECT, BCS_INDIRECT, BCS_RELATIVE
  } bcs_mode_t;
endpackage : bcs_pkg

// ==== logic/bcs_sequencer.sv ====
// Purpose: Condition evaluation and branch control of a program sequencer
// Assumes: Execute-stage instruction fields arrive decoded, one per cycle
// Notes: All outputs registered, so a redirect shows the cycle after execute
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps

// Function
// - Codes 16 to 30 complement codes 0 to 14
// - Code 15 terminates loop when count is one
// - Code 15 condition true when count not one
// - Code 31: loop never ends, instruction always runs
// - Return jumps to stack top and pops
// - Interrupt return pops status stack when pushed
// - Interrupt return clears latch and mask pointer bits
// - Call pushes return address, jump pushes nothing
// - Branch follows one condition, none means taken
// - Indirect target comes from address generator
// - Direct target is 24-bit immediate
// - Relative target is immediate plus PC
// - Delayed modifier selects delayed handling
// - Nondelayed branch squashes two following instructions
// - Nondelayed call pushes decode address
// - Delayed branch runs two slots, call pushes n+3
// - Loop abort pops PC and loop stacks once
// - Loop started in slot flushes jump target
// - Delayed jump in first slot overrides target
// - Bus master condition needs mode bits clear
// - Bit test condition reads status bit 18
// - Interrupts held through delayed branch and slots
module bcs_sequencer (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Status sources
  input wire logic [31:0] arith_status_reg_i,
  input wire logic [31:0] mode_control_one_i,
  input wire logic [3:0] flag_input_i,
  input wire logic bus_owner_i,
  input wire logic [31:0] current_loop_count_i,
  // Execute-stage branch request
  input wire logic br_valid_i,
  input wire logic [1:0] br_kind_i,
  input wire logic [1:0] br_mode_i,
  input wire logic br_has_cond_i,
  input wire logic [4:0] br_cond_i,
  input wire logic delayed_branch_modifier_i,
  input wire logic loop_abort_modifier_i,
  input wire logic in_loop_i,
  input wire logic [23:0] br_imm_i,
  input wire logic [23:0] exec_pc_i,
  input wire logic [23:0] decode_addr_i,
  input wire logic [23:0] program_data_address_gen_i,
  input wire logic [23:0] pc_stack_top_i,
  input wire logic rti_status_pushed_i,
  input wire logic [31:0] rti_service_bit_i,
  input wire logic loop_start_i,
  // Loop termination query
  input wire logic [4:0] term_cond_i,
  // Fetch and stack control
  output logic fetch_redirect_o,
  output logic [23:0] fetch_target_o,
  output logic squash_o,
  output logic pc_push_o,
  output logic [23:0] pc_push_data_o,
  output logic pc_pop_o,
  output logic loop_pop_o,
  output logic status_pop_o,
  output logic [31:0] interrupt_latch_clr_o,
  output logic [31:0] interrupt_mask_pointer_clr_o,
  output logic cond_true_o,
  output logic term_true_o,
  output logic irq_hold_o
);
  typedef enum logic [2:0] {
    BCS_IDLE, BCS_NOP1, BCS_NOP2, BCS_SLOT1, BCS_SLOT2
  } bcs_state_t;

  typedef struct packed {
    bcs_state_t state;
    logic redirect;
    logic [23:0] target;
    logic squash;
    logic push;
    logic [23:0] push_data;
    logic pop_pc;
    logic pop_loop;
    logic pop_stat;
    logic [31:0] clr_latch;
    logic [31:0] clr_mask;
    logic cond_true;
    logic term_true;
    logic irq_hold;
    logic hold_en;
    logic [15:0] taken_cnt;
    logic [23:0] last_target;
    logic [31:0] rdata;
  } bcs_st_t;

  bcs_st_t st_reg;
  bcs_st_t st_next;

  // Shared evaluation of the fifteen base codes
  function automatic logic base_cond(input logic [3:0] code,
                                     input logic [31:0] ast,
                                     input logic [31:0] md,
                                     input logic [3:0] fin,
                                     input logic bm);
    logic lt;
    logic res;
    lt = (!ast[bcs_pkg::ST_AF] & (ast[bcs_pkg::ST_AN] ^
         (ast[bcs_pkg::ST_AV] & !md[bcs_pkg::MD_ALU_SATURATE_ENABLE]))) |
         (ast[bcs_pkg::ST_AF] & ast[bcs_pkg::ST_AN] &
         !ast[bcs_pkg::ST_AZ]);
    res = 1'b0;
    if (code == 4'h0) begin
      res = ast[bcs_pkg::ST_AZ];
    end else if (code == bcs_pkg::COND_LT[3:0]) begin
      res = lt;
    end else if (code == bcs_pkg::COND_LE[3:0]) begin
      res = lt | ast[bcs_pkg::ST_AZ];
    end else if (code == 4'h3) begin
      res = ast[bcs_pkg::ST_AC];
    end else if (code == 4'h4) begin
      res = ast[bcs_pkg::ST_AV];
    end else if (code == 4'h5) begin
      res = ast[bcs_pkg::ST_MV];
    end else if (code == 4'h6) begin
      res = ast[bcs_pkg::ST_MN];
    end else if (code == 4'h7) begin
      res = ast[bcs_pkg::ST_SV];
    end else if (code == 4'h8) begin
      res = ast[bcs_pkg::ST_SZ];
    end else if (code >= bcs_pkg::COND_FLAG0[3:0] && code <= 4'hC) begin
      res = fin[2'(code - bcs_pkg::COND_FLAG0[3:0])];
    end else if (code == 4'hD) begin
      res = ast[bcs_pkg::ST_BTF];
    end else if (code == bcs_pkg::COND_BM[3:0]) begin
      // Bus ownership only reported with both mode bits clear
      res = bm & !md[bcs_pkg::MD_BM_LO] & !md[bcs_pkg::MD_BM_HI];
    end
    return res;
  endfunction : base_cond

  // Full code decode; loop context flips codes 15 and 31
  function automatic logic eval_cond(input logic [4:0] code,
                                     input logic term_ctx,
                                     input logic [31:0] ast,
                                     input logic [31:0] md,
                                     input logic [3:0] fin,
                                     input logic bm,
                                     input logic [31:0] lcnt);
    logic res;
    res = 1'b0;
    if (code == bcs_pkg::COND_LCE) begin
      res = term_ctx ? (lcnt == bcs_pkg::LOOP_LAST)
                     : (lcnt != bcs_pkg::LOOP_LAST);
    end else if (code == bcs_pkg::COND_ALWAYS) begin
      res = !term_ctx;
    end else if (code[4]) begin
      res = !base_cond(code[3:0], ast, md, fin, bm);
    end else begin
      res = base_cond(code[3:0], ast, md, fin, bm);
    end
    return res;
  endfunction : eval_cond

  logic taken;
  logic br_cond;
  logic [23:0] br_target;

  // Condition and target for the branch now in execute
  always_comb begin
    br_cond = eval_cond(br_cond_i, 1'b0, arith_status_reg_i,
                        mode_control_one_i, flag_input_i, bus_owner_i,
                        current_loop_count_i);
    taken = br_valid_i & (!br_has_cond_i | br_cond);
    if (br_kind_i == bcs_pkg::BCS_RTS || br_kind_i == bcs_pkg::BCS_RTI) begin
      br_target = pc_stack_top_i;
    end else if (br_mode_i == bcs_pkg::BCS_INDIRECT) begin
      br_target = program_data_address_gen_i;
    end else if (br_mode_i == bcs_pkg::BCS_RELATIVE) begin
      br_target = exec_pc_i + br_imm_i;
    end else begin
      br_target = br_imm_i;
    end
  end

  // Next-state logic; pulses default low every cycle
  always_comb begin
    st_next = st_reg;
    st_next.redirect = 1'b0;
    st_next.squash = 1'b0;
    st_next.push = 1'b0;
    st_next.pop_pc = 1'b0;
    st_next.pop_loop = 1'b0;
    st_next.pop_stat = 1'b0;
    st_next.clr_latch = '0;
    st_next.clr_mask = '0;
    st_next.rdata = '0;
    st_next.cond_true = br_cond;
    st_next.term_true = eval_cond(term_cond_i, 1'b1, arith_status_reg_i,
                                  mode_control_one_i, flag_input_i,
                                  bus_owner_i, current_loop_count_i);
    case (st_reg.state)
      BCS_NOP1: begin
        st_next.squash = 1'b1;
        st_next.state = BCS_NOP2;
      end
      BCS_NOP2: begin
        st_next.state = BCS_IDLE;
      end
      BCS_SLOT1: begin
        st_next.state = BCS_SLOT2;
        if (loop_start_i) begin
          // Loop fetches displace the jump; resume sequentially
          st_next.redirect = 1'b1;
          st_next.target = exec_pc_i + bcs_pkg::SEQ_STEP;
          st_next.state = BCS_IDLE;
        end else if (taken && delayed_branch_modifier_i &&
                     br_kind_i == bcs_pkg::BCS_JUMP) begin
          // Second jump wins; its one slot runs, the other is skipped
          st_next.redirect = 1'b1;
          st_next.target = br_target;
          st_next.last_target = br_target;
          st_next.squash = 1'b1;
          st_next.taken_cnt = st_reg.taken_cnt + 16'h0001;
        end
      end
      BCS_SLOT2: begin
        st_next.state = BCS_IDLE;
        if (loop_start_i) begin
          st_next.redirect = 1'b1;
          st_next.target = exec_pc_i + bcs_pkg::SEQ_STEP;
        end
      end
      default: begin
        if (taken) begin
          st_next.redirect = 1'b1;
          st_next.target = br_target;
          st_next.last_target = br_target;
          st_next.taken_cnt = st_reg.taken_cnt + 16'h0001;
          if (delayed_branch_modifier_i) begin
            st_next.state = BCS_SLOT1;
          end else begin
            st_next.squash = 1'b1;
            st_next.state = BCS_NOP1;
          end
          if (br_kind_i == bcs_pkg::BCS_CALL) begin
            st_next.push = 1'b1;
            st_next.push_data = delayed_branch_modifier_i ?
              exec_pc_i + bcs_pkg::CALL_DB_OFS
              : decode_addr_i;
          end else if (br_kind_i == bcs_pkg::BCS_JUMP) begin
            // Abort pops exactly one level of each stack
            st_next.pop_pc = loop_abort_modifier_i & in_loop_i;
            st_next.pop_loop = loop_abort_modifier_i & in_loop_i;
          end else begin
            st_next.pop_pc = 1'b1;
            if (br_kind_i == bcs_pkg::BCS_RTI) begin
              st_next.pop_stat = rti_status_pushed_i;
              st_next.clr_latch = rti_service_bit_i;
              st_next.clr_mask = rti_service_bit_i;
            end
          end
        end
      end
    endcase
    // Interrupts wait while a delayed branch or its slots run
    st_next.irq_hold = st_reg.hold_en &&
      ((st_next.state == BCS_SLOT1) || (st_next.state == BCS_SLOT2));
    // Register writes; control bit steers interrupt holding
    if (reg_wr_i) begin
      if (reg_addr_i == bcs_pkg::REG_CTRL) begin
        st_next.hold_en = reg_wdata_i[0];
      end else if (reg_addr_i == bcs_pkg::REG_COUNT) begin
        st_next.taken_cnt = '0;
      end
    end
    // Read data stands in the following cycle only
    if (reg_rd_i) begin
      if (reg_addr_i == bcs_pkg::REG_CTRL) begin
        st_next.rdata = {31'h0, st_reg.hold_en};
      end else if (reg_addr_i == bcs_pkg::REG_STATUS) begin
        st_next.rdata = {28'h0, st_reg.irq_hold, 3'(st_reg.state)};
      end else if (reg_addr_i == bcs_pkg::REG_COUNT) begin
        st_next.rdata = {16'h0, st_reg.taken_cnt};
      end else if (reg_addr_i == bcs_pkg::REG_TARGET) begin
        st_next.rdata = {8'h0, st_reg.last_target};
      end
    end
  end

  // Single state register, reset to constants
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.state <= BCS_IDLE;
      st_reg.hold_en <= bcs_pkg::CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fetch_redirect_o = st_reg.redirect;
  assign fetch_target_o = st_reg.target;
  assign squash_o = st_reg.squash;
  assign pc_push_o = st_reg.push;
  assign pc_push_data_o = st_reg.push_data;
  assign pc_pop_o = st_reg.pop_pc;
  assign loop_pop_o = st_reg.pop_loop;
  assign status_pop_o = st_reg.pop_stat;
  assign interrupt_latch_clr_o = st_reg.clr_latch;
  assign interrupt_mask_pointer_clr_o = st_reg.clr_mask;
  assign cond_true_o = st_reg.cond_true;
  assign term_true_o = st_reg.term_true;
  assign irq_hold_o = st_reg.irq_hold;
  assign reg_rdata_o = st_reg.rdata;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  wire idle_now = (st_reg.state == BCS_IDLE);
  wire go = idle_now && taken;
  sequence s_nd_go;
    go && !delayed_branch_modifier_i;
  endsequence
  sequence s_two_squash;
    squash_o [*2] ##1 !squash_o;
  endsequence

  property p_comp;
    (br_cond_i[4] && br_cond_i != bcs_pkg::COND_ALWAYS) |=>
      cond_true_o != $past(base_cond(br_cond_i[3:0], arith_status_reg_i,
        mode_control_one_i, flag_input_i, bus_owner_i));
  endproperty
  a_comp: assert property (p_comp) else $error("complement wrong");
  property p_lce;
    term_cond_i == bcs_pkg::COND_LCE |=>
      term_true_o == ($past(current_loop_count_i) == bcs_pkg::LOOP_LAST);
  endproperty
  a_lce: assert property (p_lce) else $error("loop expiry wrong");
  property p_forever;
    term_cond_i == bcs_pkg::COND_ALWAYS |=> !term_true_o;
  endproperty
  a_forever: assert property (p_forever) else $error("forever ends");
  property p_nondelayed;
    s_nd_go |=> (fetch_redirect_o) and s_two_squash;
  endproperty
  a_nondelayed: assert property (p_nondelayed)
    else $error("nondelayed squash wrong");
  property p_call_nd;
    s_nd_go and (br_kind_i == bcs_pkg::BCS_CALL) |=>
      pc_push_o && pc_push_data_o == $past(decode_addr_i);
  endproperty
  a_call_nd: assert property (p_call_nd) else $error("bad nd push");
  property p_call_db;
    go && delayed_branch_modifier_i && br_kind_i == bcs_pkg::BCS_CALL |=>
      pc_push_o && !squash_o &&
      pc_push_data_o == $past(exec_pc_i) + bcs_pkg::CALL_DB_OFS;
  endproperty
  a_call_db: assert property (p_call_db) else $error("bad db push");
  property p_jump_nopush;
    go && br_kind_i == bcs_pkg::BCS_JUMP |=> !pc_push_o;
  endproperty
  a_jump_nopush: assert property (p_jump_nopush)
    else $error("jump pushed");
  property p_ret;
    go && br_kind_i == bcs_pkg::BCS_RTS |=>
      pc_pop_o && fetch_target_o == $past(pc_stack_top_i);
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_abort;
    go && br_kind_i == bcs_pkg::BCS_JUMP && loop_abort_modifier_i &&
      in_loop_i |=> pc_pop_o && loop_pop_o ##1 !pc_pop_o && !loop_pop_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort pops wrong");
  property p_hold;
    go && delayed_branch_modifier_i && st_reg.hold_en |=>
      irq_hold_o ##1 (irq_hold_o || idle_now);
  endproperty
  a_hold: assert property (p_hold) else $error("irq not held");
  property p_bm;
    (mode_control_one_i[bcs_pkg::MD_BM_LO] ||
     mode_control_one_i[bcs_pkg::MD_BM_HI]) &&
     br_cond_i == bcs_pkg::COND_BM |=> !cond_true_o;
  endproperty
  a_bm: assert property (p_bm) else $error("bus master leaks");
endmodule : bcs_sequencer

// ==== tb/bcs_partner.sv ====
// Purpose: Return address stack model on the far side of the sequencer
// Assumes: Push and pop pulses arrive one cycle wide, never together
// Notes: An empty stack shows the inverse of the last top, not a clean 0
`timescale 1ns/100ps
module bcs_partner (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic push_i,
  input wire logic [23:0] push_data_i,
  input wire logic pop_i,
  output logic [23:0] stack_top_o
);
  logic [23:0] mem_reg [0:7];
  logic [3:0] depth_reg;
  logic [23:0] last_reg;

  // Stack update; a pop on empty is dropped, like a real underflow
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      depth_reg <= 4'h0;
      last_reg <= 24'h000000;
    end else if (push_i) begin
      mem_reg[depth_reg[2:0]] <= push_data_i;
      depth_reg <= depth_reg + 4'h1;
    end else if (pop_i && depth_reg != 4'h0) begin
      last_reg <= stack_top_o;
      depth_reg <= depth_reg - 4'h1;
    end
  end

  // Top of stack; stale data is hidden so it cannot pass by luck
  assign stack_top_o = (depth_reg != 4'h0) ? mem_reg[depth_reg[2:0] - 3'h1]
                                           : ~last_reg;
endmodule : bcs_partner

// ==== tb/tb_bcs_sequencer.sv ====
// Purpose: Self-checking bench for the branch and condition sequencer
// Assumes: Every registered output answers one cycle after its request
// Notes: Each scenario is its own task and checks before returning
`timescale 1ns/100ps
module tb_bcs_sequencer;
  logic core_clk_i, nrst_i, reg_wr_i, reg_rd_i;
  logic [3:0] reg_addr_i, fin;
  logic [31:0] reg_wdata_i, reg_rdata_o, ast, md, lcnt, svc, lclr, mclr;
  logic bm, valid, has_cond, dbm, lam, inl, pushed, lstart;
  logic [1:0] kind, mode;
  logic [4:0] cond, tcond;
  logic [23:0] imm, epc, dpc, dag, top, tgt, pdata;
  logic redir, squash, push, pop, lpop, spop, ctrue, ttrue, hold;
  int num_errors, total_checks;

  bcs_sequencer u_bcs_sequencer (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .arith_status_reg_i(ast), .mode_control_one_i(md), .flag_input_i(fin),
    .bus_owner_i(bm), .current_loop_count_i(lcnt), .br_valid_i(valid),
    .br_kind_i(kind), .br_mode_i(mode), .br_has_cond_i(has_cond),
    .br_cond_i(cond), .delayed_branch_modifier_i(dbm),
    .loop_abort_modifier_i(lam), .in_loop_i(inl), .br_imm_i(imm),
    .exec_pc_i(epc), .decode_addr_i(dpc), .program_data_address_gen_i(dag),
    .pc_stack_top_i(top), .rti_status_pushed_i(pushed),
    .rti_service_bit_i(svc), .loop_start_i(lstart), .term_cond_i(tcond),
    .fetch_redirect_o(redir), .fetch_target_o(tgt), .squash_o(squash),
    .pc_push_o(push), .pc_push_data_o(pdata), .pc_pop_o(pop),
    .loop_pop_o(lpop), .status_pop_o(spop),
    .interrupt_latch_clr_o(lclr), .interrupt_mask_pointer_clr_o(mclr),
    .cond_true_o(ctrue), .term_true_o(ttrue), .irq_hold_o(hold));

  bcs_partner u_bcs_partner (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .push_i(push), .push_data_i(pdata), .pop_i(pop), .stack_top_o(top));

  // Free-running core clock, 8 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Independent model of the condition table
  function automatic logic exp_cond(input logic [4:0] c, input logic term);
    logic [14:0] b;
    logic lt;
    logic az;
    logic an;
    logic af;
    az = ast[bcs_pkg::ST_AZ];
    an = ast[bcs_pkg::ST_AN];
    af = ast[bcs_pkg::ST_AF];
    lt = (!af & (an ^ (ast[bcs_pkg::ST_AV] & !md[bcs_pkg::MD_ALU_SATURATE_ENABLE])))
      | (af & an & !az);
    b = {bm & !md[bcs_pkg::MD_BM_HI] & !md[bcs_pkg::MD_BM_LO],
      ast[bcs_pkg::ST_BTF], fin, ast[bcs_pkg::ST_SZ], ast[bcs_pkg::ST_SV],
      ast[bcs_pkg::ST_MN], ast[bcs_pkg::ST_MV], ast[bcs_pkg::ST_AV],
      ast[bcs_pkg::ST_AC], lt | az, lt, az};
    if (c == 5'h0F) return term ? (lcnt == 32'h1) : (lcnt != 32'h1);
    if (c == 5'h1F) return !term;
    return c[4] ? !b[c[3:0]] : b[c[3:0]];
  endfunction : exp_cond

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask : rd

  // One branch pulse; returns 1 ns into the answer cycle
  task automatic issue(input logic [1:0] k, input logic [1:0] m,
      input logic d, input logic [23:0] v);
    @(posedge core_clk_i);
    kind <= k;
    mode <= m;
    dbm <= d;
    imm <= v;
    valid <= 1'b1;
    @(posedge core_clk_i);
    valid <= 1'b0;
    #1;
  endtask : issue

  task automatic gap();
    repeat (4) @(posedge core_clk_i);
  endtask : gap

  task automatic test_conditions();
    logic [31:0] pats [4];
    pats = '{32'h0000_0000, 32'h0004_1CCF, 32'h0000_0404, 32'h0000_0006};
    for (int p = 0; p < 4; p++) begin
      @(posedge core_clk_i);
      ast <= pats[p];
      md <= (p == 3) ? 32'h0002_2000 : ((p == 2) ? 32'h0004_0000 : 32'h0);
      fin <= 4'(p * 5);
      bm <= (p != 0);
      lcnt <= 32'(p);
      for (int c = 0; c < 32; c++) begin
        @(posedge core_clk_i);
        cond <= 5'(c);
        tcond <= 5'(c);
        @(posedge core_clk_i);
        #1;
        chk(ctrue, exp_cond(5'(c), 1'b0)); // Codes
        chk(ttrue, exp_cond(5'(c), 1'b1)); // Loop end
      end
    end
  endtask : test_conditions

  task automatic test_regs_jump();
    wr(4'h8, 32'h0);
    issue(bcs_pkg::BCS_JUMP, bcs_pkg::BCS_DIRECT, 1'b0, 24'h00_1234);
    chk(tgt, 32'h1234); // Direct target
    chk(push, 1'b0); // Jump pushes nothing
    chk(squash, 1'b1); // First nop cycle
    @(posedge core_clk_i);
    #1;
    chk(squash, 1'b1); // Second nop cycle
    gap();
    rd(4'h8, 32'h1); // Taken count
    rd(4'h0, 32'h1);
    rd(4'hC, 32'h1234);
    rd(4'h4, 32'h0); // Idle state, no hold
    rd(4'h2, 32'h0);
  endtask : test_regs_jump

  task automatic test_call_return();
    issue(bcs_pkg::BCS_CALL, bcs_pkg::BCS_DIRECT, 1'b0, 24'h00_2000);
    chk({push, pdata}, {1'b1, dpc}); // Return is decode address
    gap();
    issue(bcs_pkg::BCS_RTS, bcs_pkg::BCS_DIRECT, 1'b0, 24'h00_0000);
    chk({redir, pop, tgt}, {2'h3, 24'h00_0101}); // Stack top
    gap();
  endtask : test_call_return

  task automatic test_delayed_rti();
    epc <= 24'h00_0200;
    // Slots hold no stack pops
    issue(bcs_pkg::BCS_CALL, bcs_pkg::BCS_RELATIVE, 1'b1, 24'hFF_FFF0);
    chk(tgt, 32'h0001F0); // Relative target wraps
    chk(pdata, 32'h000203); // Delayed return address
    chk({squash, hold}, 2'h1); // Slots run, interrupts held
    @(posedge core_clk_i);
    #1;
    chk({squash, hold}, 2'h1); // Second slot
    gap();
    pushed <= 1'b1;
    svc <= 32'h0000_0040;
    issue(bcs_pkg::BCS_RTI, bcs_pkg::BCS_DIRECT, 1'b0, 24'h00_0000);
    chk({pop, tgt}, {1'b1, 24'h00_0203}); // Return target
    chk(spop, 1'b1); // Status stack popped
    chk(lclr & mclr, 32'h0000_0040); // Bits cleared
    pushed <= 1'b0;
    gap();
  endtask : test_delayed_rti

  task automatic test_indirect_cond();
    ast <= 32'h0;
    dag <= 24'h00_3456;
    has_cond <= 1'b1;
    cond <= 5'h00;
    issue(bcs_pkg::BCS_JUMP, bcs_pkg::BCS_INDIRECT, 1'b0, 24'h00_0000);
    chk(redir, 1'b0); // False condition not taken
    gap();
    cond <= 5'h10;
    issue(bcs_pkg::BCS_JUMP, bcs_pkg::BCS_INDIRECT, 1'b0, 24'h00_0000);
    chk({redir, push, tgt}, {2'h2, 24'h00_3456}); // Indirect
    has_cond <= 1'b0;
    gap();
  endtask : test_indirect_cond

  task automatic test_loop_abort();
    inl <= 1'b1;
    lam <= 1'b1;
    // Abort sits well before the loop tail
    issue(bcs_pkg::BCS_JUMP, bcs_pkg::BCS_DIRECT, 1'b0, 24'h00_4000);
    chk({pop, lpop}, 2'h3); // Both stacks popped
    @(posedge core_clk_i);
    #1;
    chk({pop, lpop}, 2'h0); // Only once
    inl <= 1'b0;
    lam <= 1'b0;
    gap();
  endtask : test_loop_abort

  task automatic test_slots();
    epc <= 24'h00_0300;
    issue(bcs_pkg::BCS_JUMP, bcs_pkg::BCS_DIRECT, 1'b1, 24'h00_5000);
    lstart <= 1'b1;
    epc <= 24'h00_0301;
    @(posedge core_clk_i);
    lstart <= 1'b0;
    #1;
    chk({redir, tgt}, {1'b1, 24'h00_0302}); // Loop flushes target
    gap();
    epc <= 24'h00_0400;
    issue(bcs_pkg::BCS_JUMP, bcs_pkg::BCS_DIRECT, 1'b1, 24'h00_6000);
    // Jump in a jump slot, deliberately breaking the coding
    imm <= 24'h00_7000;
    valid <= 1'b1;
    @(posedge core_clk_i);
    valid <= 1'b0;
    #1;
    chk({redir, squash, tgt}, {2'h3, 24'h00_7000}); // Second wins
    gap();
  endtask : test_slots

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    complete_run();
  end

  initial begin
    {nrst_i, reg_wr_i, reg_rd_i, reg_addr_i, fin, reg_wdata_i} = '0;
    {ast, md, lcnt, svc, bm, valid, has_cond, dbm, lam, inl} = '0;
    {pushed, lstart, kind, mode, cond, tcond, imm, epc, dag} = '0;
    dpc = 24'h00_0101;
    num_errors = 0;
    total_checks = 0;
    repeat (6) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    test_regs_jump();
    test_conditions();
    test_call_return();
    test_delayed_rti();
    test_indirect_cond();
    test_loop_abort();
    test_slots();
    complete_run();
  end
endmodule : tb_bcs_sequencer
